/* File: core/adcs_regs.vh */
// Constants for the converter serial control block.
// Assumes inclusion by bare name from the block's design file.
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// Command byte prefixes, most significant bits first
`define ADCS_CMD_CONV_BIT 7
`define ADCS_CMD_SETUP 2'b01
`define ADCS_CMD_AVG 3'b001
`define ADCS_CMD_RST 4'b0001

// Setup byte fields
`define ADCS_MODE_HI 5
`define ADCS_MODE_LO 4
`define ADCS_REF_HI 3
`define ADCS_REF_LO 2
`define ADCS_PAIR_HI 1
`define ADCS_PAIR_LO 0

// Clock modes, pairing selectors and differential reference code
`define ADCS_MODE_TRIG 2'b00
`define ADCS_MODE_EXT 2'b01
`define ADCS_MODE_INT 2'b10
`define ADCS_MODE_SCLK 2'b11
`define ADCS_PSEL_UNI 2'b10
`define ADCS_PSEL_BIP 2'b11
`define ADCS_REF_DIFF 2'b11

// Scan modes
`define ADCS_SCAN_LOW 2'b00
`define ADCS_SCAN_HIGH 2'b01
`define ADCS_SCAN_REP 2'b10
`define ADCS_SCAN_ONE 2'b11

// Reset values
`define ADCS_CONV_RST 8'h80
`define ADCS_SETUP_RST 6'h20
`define ADCS_AVG_RST 5'h00
`define ADCS_PAIR_RST 8'h00

`endif

/* File: core/adcs_ctrl.v */
// Serial command port, conversion sequencer and result FIFO of a
// multichannel 12-bit converter. Assumes a host SPI master on the
// pins and an analog SAR core on the same clock that answers each
// request with one done pulse carrying its code.
`timescale 1ns/1ns
`include "adcs_regs.vh"

// Result FIFO; push and pop together are legal when full
module adcs_fifo #(
    parameter W = 16,
    parameter D = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire core_clk_i,
    input wire nrst_i,
    // Fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    // Drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o,
    output wire [AW:0] level_o
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign out_valid_o = (cnt_r != 0);
    assign in_ready_o = (cnt_r != D) || out_ready_i;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_r];
    assign level_o = cnt_r;

    // Pointers wrap at the depth
    always @(posedge core_clk_i) begin
        if (!nrst_i) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_r <= (wr_r == D - 1) ? {AW{1'b0}} : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == D - 1) ? {AW{1'b0}} : rd_r + 1'b1;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // Storage
    always @(posedge core_clk_i) begin
        if (push)
            mem[wr_r] <= in_data_i;
    end
endmodule // adcs_fifo

module adcs_ctrl #(
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter CNV_CH = 4'hf,
    parameter REFN_CH = 4'he
) (
    // Clock and reset
    input wire core_clk_i,
    input wire nrst_i,
    // Serial pins
    input wire sclk_i,
    input wire cs_n_i,
    input wire din_i,
    output wire dout_o,
    output wire dout_oe_o,
    // Start pin and end flag
    input wire conv_start_n_i,
    output wire eoc_n_o,
    // Analog core request
    output reg conv_req_o,
    output reg [3:0] conv_chan_o,
    output reg conv_diff_o,
    output reg conv_temp_o,
    output wire conv_avg_on_o,
    output wire [1:0] conv_navg_o,
    // Analog core answer
    input wire conv_done_i,
    input wire [11:0] conv_code_i,
    input wire conv_neg_i,
    // Status
    output wire osc_en_o,
    output wire clk_mode_hi_o,
    output wire clk_mode_lo_o,
    output wire [1:0] ref_sel_o,
    output wire [AW:0] fifo_level_o
);
    localparam S_IDLE = 3'd0;
    localparam S_PICK = 3'd1;
    localparam S_WAIT = 3'd2;
    localparam S_HOLD = 3'd3;

    // Pin synchronisers
    reg [3:0] s1_r;
    reg [3:0] s2_r;
    reg sclk_d_r;
    reg cs_d_r;
    reg cnv_d_r;
    wire sclk_s = s2_r[0];
    wire cs_s = s2_r[1];
    wire din_s = s2_r[2];
    wire cnv_s = s2_r[3];
    wire rise = sclk_s && !sclk_d_r && !cs_s;
    wire fall = !sclk_s && sclk_d_r && !cs_s;
    wire cs_fall = !cs_s && cs_d_r;
    wire cnv_fall = !cnv_s && cnv_d_r;

    // Configuration
    reg [7:0] conv_r;
    reg [5:0] setup_r;
    reg [4:0] avg_r;
    reg [7:0] uni_r;
    reg [7:0] bip_r;
    reg pair_pend_r;
    reg pair_bip_r;
    wire [1:0] mode = setup_r[`ADCS_MODE_HI:`ADCS_MODE_LO];
    wire [1:0] refs = setup_r[`ADCS_REF_HI:`ADCS_REF_LO];

    // Serial shifters
    reg [2:0] bit_cnt_r;
    reg [6:0] in_sr_r;
    reg seen_rise_r;
    reg [7:0] out_sr_r;
    reg [7:0] lo_byte_r;
    reg half_r;
    reg show_fifo_r;
    reg show_temp_r;
    wire byte_done = rise && (bit_cnt_r == 3'd7);
    wire [7:0] cmd = {in_sr_r, din_s};

    // Sequencer
    reg [2:0] st_r;
    reg [4:0] ch_r;
    reg [3:0] last_r;
    reg [4:0] rep_r;
    reg tmp_pend_r;
    reg eoc_n_r;
    reg fifo_clr_r;

    // Results
    reg [15:0] temp_r;
    reg temp_v_r;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_head;
    reg res_v;
    reg [15:0] res_w;
    wire fetch;
    wire rd_pop;

    // Pair bit for a channel, pair 0/1 in bit 7
    function pair_of;
        input [7:0] v;
        input [3:0] ch;
        begin
            pair_of = v[3'd7 - ch[3:1]];
        end
    endfunction

    // Whether a pin serves as an analog input
    function pin_ok;
        input [3:0] ch;
        input [1:0] md;
        input [1:0] rs;
        begin
            pin_ok = !((ch == CNV_CH) && !md[1]) &&
                !((ch == REFN_CH) && (rs == `ADCS_REF_DIFF));
        end
    endfunction

    wire [3:0] ch4 = ch_r[3:0];
    wire [3:0] mate = {ch4[3:1], ~ch4[0]};
    wire ch_diff = pair_of(uni_r | bip_r, ch4);
    wire ch_use = pin_ok(ch4, mode, refs) &&
        !(ch_diff && (ch4[0] || !pin_ok(mate, mode, refs)));
    wire [4:0] ch_step = ch_r + (ch_diff ? 5'd2 : 5'd1);
    wire last_ch = (conv_r[2:1] == `ADCS_SCAN_REP) ?
        (rep_r == 5'd1) : (ch_step > {1'b0, last_r});

    assign osc_en_o = (mode != `ADCS_MODE_SCLK);
    assign clk_mode_hi_o = mode[1];
    assign clk_mode_lo_o = mode[0];
    assign ref_sel_o = refs;
    assign conv_avg_on_o = avg_r[4] && (mode != `ADCS_MODE_SCLK);
    assign conv_navg_o = avg_r[3:2];
    assign eoc_n_o = eoc_n_r || (mode == `ADCS_MODE_SCLK);
    assign dout_o = cs_s ? 1'b0 : out_sr_r[7];
    assign dout_oe_o = !cs_s;

    // Two flops on every pin before use
    always @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s1_r <= 4'hf;
            s2_r <= 4'hf;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            cnv_d_r <= 1'b1;
        end else begin
            s1_r <= {conv_start_n_i, din_i, cs_n_i, sclk_i};
            s2_r <= s1_r;
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
            cnv_d_r <= cnv_s;
        end
    end

    // Command shifter and decoder
    always @(posedge core_clk_i) begin
        if (!nrst_i) begin
            bit_cnt_r <= 3'd0;
            in_sr_r <= 7'h00;
            conv_r <= `ADCS_CONV_RST;
            setup_r <= `ADCS_SETUP_RST;
            avg_r <= `ADCS_AVG_RST;
            uni_r <= `ADCS_PAIR_RST;
            bip_r <= `ADCS_PAIR_RST;
            pair_pend_r <= 1'b0;
            pair_bip_r <= 1'b0;
            fifo_clr_r <= 1'b0;
        end else begin
            fifo_clr_r <= 1'b0;
            if (cs_s) begin
                bit_cnt_r <= 3'd0;
                pair_pend_r <= 1'b0;
            end else if (rise) begin
                bit_cnt_r <= bit_cnt_r + 3'd1;
                in_sr_r <= {in_sr_r[5:0], din_s};
            end
            if (byte_done && pair_pend_r) begin
                pair_pend_r <= 1'b0;
                if (pair_bip_r)
                    bip_r <= cmd;
                else
                    uni_r <= cmd;
            end else if (byte_done) begin
                if (cmd[`ADCS_CMD_CONV_BIT]) begin
                    conv_r <= cmd;
                end else if (cmd[7:6] == `ADCS_CMD_SETUP) begin
                    setup_r <= cmd[5:0];
                    pair_pend_r <= cmd[`ADCS_PAIR_HI];
                    pair_bip_r <= cmd[`ADCS_PAIR_LO];
                end else if (cmd[7:5] == `ADCS_CMD_AVG) begin
                    avg_r <= cmd[4:0];
                end else if (cmd[7:4] == `ADCS_CMD_RST) begin
                    fifo_clr_r <= 1'b1;
                    if (!cmd[3]) begin
                        conv_r <= `ADCS_CONV_RST;
                        setup_r <= `ADCS_SETUP_RST;
                        avg_r <= `ADCS_AVG_RST;
                        uni_r <= `ADCS_PAIR_RST;
                        bip_r <= `ADCS_PAIR_RST;
                    end
                end
            end
        end
    end

    // Start of a sequence from a command or the start pin
    wire cmd_go = byte_done && !pair_pend_r && cmd[`ADCS_CMD_CONV_BIT] &&
        mode[1];
    wire pin_go = cnv_fall && !mode[1];

    // Conversion sequencer
    always @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st_r <= S_IDLE;
            ch_r <= 5'd0;
            last_r <= 4'd0;
            rep_r <= 5'd1;
            tmp_pend_r <= 1'b0;
            conv_req_o <= 1'b0;
            conv_chan_o <= 4'd0;
            conv_diff_o <= 1'b0;
            conv_temp_o <= 1'b0;
            eoc_n_r <= 1'b1;
        end else begin
            conv_req_o <= 1'b0;
            if (cs_fall || cnv_fall || mode == `ADCS_MODE_SCLK)
                eoc_n_r <= 1'b1;
            case (st_r)
            S_IDLE: begin
                if ((cmd_go || pin_go) && !fifo_clr_r) begin
                    tmp_pend_r <= byte_done ? cmd[0] : conv_r[0];
                    st_r <= S_PICK;
                    case (mode == `ADCS_MODE_SCLK ? `ADCS_SCAN_ONE :
                          conv_r[2:1])
                    `ADCS_SCAN_LOW: begin
                        ch_r <= 5'd0;
                        last_r <= conv_r[6:3];
                    end
                    `ADCS_SCAN_HIGH: begin
                        ch_r <= {1'b0, conv_r[6:3]};
                        last_r <= 4'hf;
                    end
                    `ADCS_SCAN_REP: begin
                        ch_r <= {1'b0, conv_r[6:3]};
                        last_r <= conv_r[6:3];
                        rep_r <= {avg_r[1:0], 3'd0} + 5'd4;
                    end
                    default: begin
                        ch_r <= {1'b0, conv_r[6:3]};
                        last_r <= conv_r[6:3];
                        rep_r <= 5'd1;
                    end
                    endcase
                    if (cmd_go) begin
                        ch_r <= {1'b0, cmd[6:3]};
                        last_r <= cmd[6:3];
                        if (mode == `ADCS_MODE_INT) begin
                            if (cmd[2:1] == `ADCS_SCAN_LOW)
                                ch_r <= 5'd0;
                            if (cmd[2:1] == `ADCS_SCAN_HIGH)
                                last_r <= 4'hf;
                            rep_r <= (cmd[2:1] == `ADCS_SCAN_REP) ?
                                {avg_r[1:0], 3'd0} + 5'd4 : 5'd1;
                        end else begin
                            rep_r <= 5'd1;
                        end
                    end
                end
            end
            S_PICK: begin
                if (tmp_pend_r) begin
                    conv_req_o <= 1'b1;
                    conv_temp_o <= 1'b1;
                    conv_diff_o <= 1'b0;
                    st_r <= S_WAIT;
                end else if (ch_r[4] || ch4 > last_r) begin
                    eoc_n_r <= (mode == `ADCS_MODE_SCLK);
                    st_r <= S_IDLE;
                end else if (ch_use) begin
                    conv_req_o <= 1'b1;
                    conv_temp_o <= 1'b0;
                    conv_chan_o <= ch4;
                    conv_diff_o <= ch_diff;
                    st_r <= S_WAIT;
                end else begin
                    ch_r <= ch_step;
                end
            end
            S_WAIT: begin
                if (conv_done_i && (fifo_in_ready || conv_temp_o)) begin
                    if (conv_temp_o) begin
                        tmp_pend_r <= 1'b0;
                    end else if (last_ch) begin
                        ch_r <= 5'h10;
                    end else if (conv_r[2:1] == `ADCS_SCAN_REP &&
                                 mode != `ADCS_MODE_SCLK) begin
                        rep_r <= rep_r - 5'd1;
                    end else begin
                        ch_r <= ch_step;
                    end
                    if (mode == `ADCS_MODE_EXT) begin
                        eoc_n_r <= 1'b0;
                        st_r <= S_HOLD;
                    end else begin
                        st_r <= S_PICK;
                    end
                end
            end
            S_HOLD: begin
                if (cnv_fall)
                    st_r <= S_PICK;
                else if (!tmp_pend_r && (ch_r[4] || ch4 > last_r))
                    st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
            endcase
        end
    end

    // Result coding into a two-byte word
    always @* begin
        res_v = conv_done_i && (st_r == S_WAIT) && !conv_temp_o;
        if (conv_neg_i && !pair_of(bip_r, conv_chan_o))
            res_w = 16'h0000;
        else if (conv_diff_o && pair_of(bip_r, conv_chan_o))
            res_w = {4'h0, ~conv_code_i[11], conv_code_i[10:0]};
        else
            res_w = {4'h0, conv_code_i};
    end

    // High byte shown at a word boundary; word leaves once its high byte is clocked out
    assign fetch = !half_r && (cs_fall ||
        (fall && seen_rise_r && bit_cnt_r == 3'd0));
    assign rd_pop = byte_done && !half_r && show_fifo_r;

    // Output shifter and temperature slot
    always @(posedge core_clk_i) begin
        if (!nrst_i) begin
            out_sr_r <= 8'h00;
            lo_byte_r <= 8'h00;
            half_r <= 1'b0;
            show_fifo_r <= 1'b0;
            show_temp_r <= 1'b0;
            seen_rise_r <= 1'b0;
            temp_r <= 16'h0000;
            temp_v_r <= 1'b0;
        end else begin
            if (cs_fall)
                seen_rise_r <= 1'b0;
            else if (rise)
                seen_rise_r <= 1'b1;
            if (fifo_clr_r) begin
                half_r <= 1'b0;
                show_fifo_r <= 1'b0;
                show_temp_r <= 1'b0;
            end else if (byte_done &&
                         (half_r || show_fifo_r || show_temp_r)) begin
                half_r <= !half_r;
            end
            if (fetch) begin
                show_temp_r <= temp_v_r;
                show_fifo_r <= !temp_v_r && fifo_out_valid;
                if (temp_v_r) begin
                    out_sr_r <= temp_r[15:8];
                    lo_byte_r <= temp_r[7:0];
                end else if (fifo_out_valid) begin
                    out_sr_r <= fifo_head[15:8];
                    lo_byte_r <= fifo_head[7:0];
                end else begin
                    out_sr_r <= 8'h00;
                    lo_byte_r <= 8'h00;
                end
            end else if (cs_fall ||
                         (fall && seen_rise_r && bit_cnt_r == 3'd0)) begin
                out_sr_r <= lo_byte_r;
            end else if (fall && seen_rise_r) begin
                out_sr_r <= {out_sr_r[6:0], 1'b0};
            end
            if ((byte_done && !half_r && show_temp_r) || fifo_clr_r)
                temp_v_r <= 1'b0;
            if (conv_done_i && st_r == S_WAIT && conv_temp_o) begin
                temp_r <= {4'h0, conv_code_i};
                temp_v_r <= 1'b1;
            end
        end
    end

    // Full FIFO drops its oldest word to take the newest
    adcs_fifo #(
        .W(16),
        .D(DEPTH),
        .AW(AW)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i && !fifo_clr_r),
        .in_valid_i(res_v),
        .in_ready_o(fifo_in_ready),
        .in_data_i(res_w),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(rd_pop || (res_v && fifo_level_o == DEPTH)),
        .out_data_o(fifo_head),
        .level_o(fifo_level_o)
    );
endmodule // adcs_ctrl

/* File: verif/adcs_ctrl_sva.sv */
// Port-level checker for the converter serial control block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ns
module adcs_ctrl_sva #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire core_clk_i,
    input wire nrst_i,
    // Pins
    input wire sclk_i,
    input wire cs_n_i,
    input wire dout_o,
    input wire dout_oe_o,
    input wire conv_start_n_i,
    input wire eoc_n_o,
    // Core side and status
    input wire conv_req_o,
    input wire conv_done_i,
    input wire conv_avg_on_o,
    input wire osc_en_o,
    input wire clk_mode_hi_o,
    input wire clk_mode_lo_o,
    input wire [AW:0] fifo_level_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // Serial output released while deselected
    a_oe_deselect: assert property (cs_n_i [*3] |-> !dout_oe_o)
        else $error("serial output enabled while deselected");
    a_dout_quiet: assert property (!dout_oe_o |-> !dout_o)
        else $error("serial output not quiet");
    // Output bit moves only after a clock fall or select fall
    a_dout_fall: assert property ($changed(dout_o) && $past(dout_oe_o)
        |-> !$past(sclk_i, 3) || $past(cs_n_i, 3))
        else $error("serial output moved outside a falling edge");
    // Mode fields and oscillator
    a_osc_mode: assert property (osc_en_o == !(clk_mode_hi_o && clk_mode_lo_o))
        else $error("oscillator enable wrong for mode");
    a_eoc_mode3: assert property (clk_mode_hi_o && clk_mode_lo_o |-> eoc_n_o)
        else $error("end flag low in serial-clock mode");
    a_avg_mode3: assert property (clk_mode_hi_o && clk_mode_lo_o |-> !conv_avg_on_o)
        else $error("averaging on in serial-clock mode");
    // End flag released by select or start fall
    a_eoc_csfall: assert property ($fell(cs_n_i) ##1 (!conv_done_i) [*4]
        |-> eoc_n_o)
        else $error("end flag not released by select fall");
    a_eoc_stfall: assert property ($fell(conv_start_n_i) ##1 (!conv_done_i) [*4]
        |-> eoc_n_o)
        else $error("end flag not released by start fall");
    a_eoc_each: assert property (!clk_mode_hi_o && clk_mode_lo_o && conv_done_i
        |=> !eoc_n_o)
        else $error("end flag missing after single conversion");
    a_req_single: assert property (conv_req_o |=> !conv_req_o)
        else $error("request longer than one cycle");
    a_fifo_bound: assert property (fifo_level_o <= DEPTH)
        else $error("result level above depth");

    // Main scenarios
    c_eoc_low: cover property ($fell(eoc_n_o));
    c_full: cover property (fifo_level_o == DEPTH);
    c_start_pulse: cover property ($fell(conv_start_n_i) ##[1:20] conv_req_o);
endmodule // adcs_ctrl_sva

bind adcs_ctrl adcs_ctrl_sva #(.DEPTH(DEPTH), .AW(AW)) u_sva (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .dout_o(dout_o),
    .dout_oe_o(dout_oe_o),
    .conv_start_n_i(conv_start_n_i),
    .eoc_n_o(eoc_n_o),
    .conv_req_o(conv_req_o),
    .conv_done_i(conv_done_i),
    .conv_avg_on_o(conv_avg_on_o),
    .osc_en_o(osc_en_o),
    .clk_mode_hi_o(clk_mode_hi_o),
    .clk_mode_lo_o(clk_mode_lo_o),
    .fifo_level_o(fifo_level_o)
);

/* File: verif/adcs_host_model.sv */
// Host serial master model: select, clock and data toward the block.
// Assumes the bench calls its tasks; moves pins on core clock falls.
`timescale 1ns/1ns
module adcs_host_model (
    // Core clock for pacing
    input wire core_clk_i,
    // Serial pins
    input wire dout_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    // Idle: clock parked low, select high
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end

    // Select fall opens a frame
    task frame_open;
        begin
            @(negedge core_clk_i) cs_n_o = 1'b0;
            repeat (4) @(negedge core_clk_i);
        end
    endtask

    // Select rise; released data line shows inverse of last bit
    task frame_close;
        begin
            repeat (4) @(negedge core_clk_i);
            cs_n_o = 1'b1;
            din_o = ~din_o;
            repeat (4) @(negedge core_clk_i);
        end
    endtask

    // MSB first, 800 ns clock, idle low with rise sampling
    task shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        int i;
        begin
            rx = 8'h00;
            for (i = 0; i < n; i++) begin
                din_o = tx[7-i];
                repeat (4) @(negedge core_clk_i);
                sclk_o = 1'b1;
                rx = {rx[6:0], dout_i};
                repeat (4) @(negedge core_clk_i);
                sclk_o = 1'b0;
            end
        end
    endtask
endmodule // adcs_host_model

/* File: verif/adcs_ctrl_tb.sv */
// Self-checking bench for the converter serial control block.
// Assumes the host model and a behavioural analog core stand-in.
`timescale 1ns/1ns
module adcs_ctrl_tb;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic conv_start_n_i = 1'b1;
    logic conv_done_i = 1'b0;
    logic conv_neg_i = 1'b0;
    logic [11:0] conv_code_i = 12'h000;
    logic [2:0] dly_r = 3'h0;
    wire sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, eoc_n_o, conv_req_o;
    wire conv_diff_o, conv_temp_o, conv_avg_on_o, osc_en_o;
    wire clk_mode_hi_o, clk_mode_lo_o;
    wire [3:0] conv_chan_o;
    wire [1:0] conv_navg_o, ref_sel_o;
    wire [4:0] fifo_level_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [7:0] rx;
    logic [15:0] w;
    int k;

    // 10 MHz core clock
    always #50 core_clk_i = ~core_clk_i;

    adcs_ctrl dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
        .dout_oe_o(dout_oe_o), .conv_start_n_i(conv_start_n_i),
        .eoc_n_o(eoc_n_o), .conv_req_o(conv_req_o),
        .conv_chan_o(conv_chan_o), .conv_diff_o(conv_diff_o),
        .conv_temp_o(conv_temp_o), .conv_avg_on_o(conv_avg_on_o),
        .conv_navg_o(conv_navg_o), .conv_done_i(conv_done_i),
        .conv_code_i(conv_code_i), .conv_neg_i(conv_neg_i),
        .osc_en_o(osc_en_o), .clk_mode_hi_o(clk_mode_hi_o),
        .clk_mode_lo_o(clk_mode_lo_o), .ref_sel_o(ref_sel_o),
        .fifo_level_o(fifo_level_o));

    adcs_host_model host (.core_clk_i(core_clk_i), .dout_i(dout_o),
        .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));

    // Analog core stand-in: done four cycles after each request
    always @(negedge core_clk_i) begin
        conv_done_i <= (dly_r == 3'h1);
        if (dly_r != 3'h0)
            dly_r <= dly_r - 3'h1;
        if (conv_req_o === 1'b1) begin
            dly_r <= 3'h4;
            conv_code_i <= conv_temp_o ? 12'hf38 : {conv_chan_o, 8'h5a};
        end
    end

    task complete_run;
        begin
            if (n_mismatch == 0 && cmp_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            cmp_count++;
            if (got !== exp) begin
                n_mismatch++;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // One command byte in its own frame
    task send(input logic [7:0] b);
        begin
            host.frame_open();
            host.shift(b, 8, rx);
            host.frame_close();
        end
    endtask

    // One result word, high byte first, null commands on the input
    task read_word(output logic [15:0] v);
        begin
            host.frame_open();
            host.shift(8'h00, 8, rx);
            v[15:8] = rx;
            host.shift(8'h00, 8, rx);
            v[7:0] = rx;
            host.frame_close();
        end
    endtask

    // Low pulse on the start pin
    task start_pulse;
        begin
            @(negedge core_clk_i) conv_start_n_i = 1'b0;
            repeat (4) @(negedge core_clk_i);
            conv_start_n_i = 1'b1;
        end
    endtask

    task wait_eoc;
        int i;
        begin
            i = 0;
            while (eoc_n_o !== 1'b0 && i < 3000) begin
                @(negedge core_clk_i);
                i++;
            end
            if (i >= 3000) begin
                n_mismatch++;
                complete_run();
            end
        end
    endtask

    initial begin
        repeat (16) @(negedge core_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        chk({13'h0000, eoc_n_o, dout_oe_o, osc_en_o}, 16'h0005);
        chk({14'h0000, clk_mode_hi_o, clk_mode_lo_o}, 16'h0002);
        read_word(w);
        chk(w, 16'h0000);
        // Single conversion of channel 3 in default mode
        send(8'h9e);
        wait_eoc();
        chk({11'h000, fifo_level_o}, 16'h0001);
        read_word(w);
        chk(w, 16'h035a);
        chk({15'h0000, eoc_n_o}, 16'h0001);
        // Temperature then channels 0 and 1
        send(8'h89);
        wait_eoc();
        chk({11'h000, fifo_level_o}, 16'h0002);
        read_word(w);
        chk(w, 16'h0f38);
        read_word(w);
        chk(w, 16'h005a);
        read_word(w);
        chk(w, 16'h015a);
        // Partial byte dropped on select rise
        host.frame_open();
        host.shift(8'h70, 4, rx);
        host.frame_close();
        chk({14'h0000, clk_mode_hi_o, clk_mode_lo_o}, 16'h0002);
        // Serial-clock mode stops the oscillator
        send(8'h70);
        chk({13'h0000, clk_mode_hi_o, clk_mode_lo_o, osc_en_o}, 16'h0006);
        chk({15'h0000, eoc_n_o}, 16'h0001);
        // Start pin modes 00 and 01, one conversion each
        for (k = 0; k < 2; k++) begin
            send(k == 0 ? 8'h40 : 8'h50);
            send(8'h9e);
            start_pulse();
            wait_eoc();
            read_word(w);
            chk(w, 16'h035a);
        end
        // Bipolar pair 0/1 loaded by the byte after setup
        host.frame_open();
        host.shift(8'h63, 8, rx);
        host.shift(8'h80, 8, rx);
        host.frame_close();
        send(8'h86);
        wait_eoc();
        chk({15'h0000, conv_diff_o}, 16'h0001);
        read_word(w);
        chk(w, 16'h085a);
        // Negative single-ended input clamps to zero
        conv_neg_i = 1'b1;
        send(8'h9e);
        wait_eoc();
        chk({11'h000, fifo_level_o}, 16'h0001);
        read_word(w);
        chk(w, 16'h0000);
        conv_neg_i = 1'b0;
        // Repeat scan of channel 2 leaves four words
        send(8'h94);
        wait_eoc();
        chk({11'h000, fifo_level_o}, 16'h0004);
        // Reset command clears them and the configuration
        send(8'h10);
        chk({11'h000, fifo_level_o}, 16'h0000);
        chk({14'h0000, clk_mode_hi_o, clk_mode_lo_o}, 16'h0002);
        // Mode 00 pulses run two 12-result scans, overflow the buffer
        send(8'h40);
        send(8'hd8);
        for (k = 0; k < 2; k++) begin
            start_pulse();
            wait_eoc();
        end
        chk({11'h000, fifo_level_o}, 16'h0010);
        read_word(w);
        chk(w, 16'h085a);
        complete_run();
    end
endmodule // adcs_ctrl_tb
